// File: pvd_dma_window.sv
// DMA address and count engine with VME window and CONTROL_STATUS_REGISTERS decode
`timescale 1ns/1ps
`default_nettype none
// Operation
// - packet count is byte count over 256
// - packet count counts down, reads show remaining
// - 24-bit PCI address: offset plus map index
// - PCI address steps two or four per beat
// - VME address loads, steps four or two
// - shared RAM uses only low address bits
// - slave status write bit7 clears errors
// - decode 32 CONTROL_STATUS_REGISTERS bytes in A16
// - half of CSRs local, half over cable
// - four groups of eight CSRs
// - PCI memory window forwards over cable
// - windows enable A32, A24 uses low bits
// - shared RAM window routes to RAM
// - remainder holds byte count modulo 256
// - target select picks shared RAM or VME
// - width select picks longword or word beats
// - abort past 16 ms, flag timeout
module pvd_dma_window
#(
    parameter int TMO_CYCLES = pvd_pkg::TIMEOUT_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Jumper pins
    input wire logic [10:0] csr_base_jumpers,
    input wire logic [31:0] pci_memory_window_lo,
    input wire logic [31:0] pci_memory_window_hi,
    input wire logic [1:0] pci_memory_window_en,
    input wire logic [31:0] shared_ram_window_lo,
    input wire logic [31:0] shared_ram_window_hi,
    input wire logic [1:0] shared_ram_window_en,
    input wire logic [4:0] shared_ram_addr_bits,
    // VME access decode
    input wire logic vme_valid,
    input wire logic [31:0] vme_addr,
    input wire logic [1:0] vme_space,
    output logic hit_csr_local,
    output logic hit_csr_remote,
    output logic hit_pci_memory,
    output logic hit_shared_ram,
    // DMA data in
    input wire logic dma_in_valid,
    output logic dma_in_ready,
    input wire logic [31:0] dma_in_data,
    // DMA data out
    output logic dma_out_valid,
    input wire logic dma_out_ready,
    output logic [31:0] dma_out_data,
    output logic [31:0] dma_out_vme_addr,
    output logic [11:0] dma_out_pci_offset,
    output logic [11:0] dma_out_map_index,
    // Status
    input wire logic bus_error_event,
    output logic dma_active,
    output logic dma_to_shared_ram,
    output logic dma_longword
);
    import pvd_pkg::*;

    typedef struct packed {
        pvd_state_t state;
        logic target;
        logic longword;
        logic [15:0] pkt;
        logic [7:0] local_rem;
        logic [7:0] rem;
        logic [23:0] pci;
        logic [31:0] vme;
        logic [7:0] slave;
        logic [TMO_BITS-1:0] tmo;
        logic [1:0][$bits(pvd_entry_t)-1:0] buffer;
        logic [1:0] count;
        logic wr_ptr;
        logic rd_ptr;
        logic [7:0] rdata;
        logic rvalid;
        logic [JMP_BITS-1:0] jmp_meta;
        logic [JMP_BITS-1:0] jmp;
        logic [3:0] hits;
    } pvd_regs_t;

    pvd_regs_t cur_ff;
    pvd_regs_t nxt_cur;

    // Byte step of one beat
    function automatic logic [2:0] pvd_step(input logic longword);
        pvd_step = longword ? STEP_LONG : STEP_WORD;
    endfunction

    // Window compare; A24 uses only the low 24 bits of the jumpers
    function automatic logic pvd_in_window(input logic [31:0] addr, input logic [1:0] space,
                                           input logic [31:0] lo, input logic [31:0] hi,
                                           input logic [1:0] en);
        pvd_in_window = 1'b0;
        if (space == SPACE_A32 && en[WIN_EN_A32])
        begin
            pvd_in_window = (addr >= lo) && (addr < hi);
        end
        else if (space == SPACE_A24 && en[WIN_EN_A24])
        begin
            pvd_in_window = (addr[23:0] >= lo[23:0]) && (addr[23:0] < hi[23:0]);
        end
    endfunction

    // Address mask for the installed shared RAM size, clamped to the legal range
    function automatic logic [31:0] pvd_ram_mask(input logic [4:0] bits);
        logic [4:0] b;
        b = bits;
        if (b < RAM_BITS_MIN)
        begin
            b = RAM_BITS_MIN;
        end
        if (b > RAM_BITS_MAX)
        begin
            b = RAM_BITS_MAX;
        end
        pvd_ram_mask = (32'h1 << b) - 32'h1;
    endfunction

    // Synchronised jumper fields
    logic [10:0] j_csr;
    logic [31:0] j_pci_lo;
    logic [31:0] j_pci_hi;
    logic [1:0] j_pci_en;
    logic [31:0] j_ram_lo;
    logic [31:0] j_ram_hi;
    logic [1:0] j_ram_en;
    logic [4:0] j_ram_bits;
    assign {j_csr, j_pci_lo, j_pci_hi, j_pci_en, j_ram_lo, j_ram_hi, j_ram_en, j_ram_bits} = cur_ff.jmp;

    // Handshakes and beat bookkeeping
    logic push;
    logic pop;
    logic [23:0] total;
    logic [23:0] total_after;
    logic [2:0] step;
    logic [31:0] eff_vme;
    pvd_entry_t head;
    assign dma_in_ready = (cur_ff.state == PVD_RUN) && (cur_ff.count != BUF_DEPTH);
    assign dma_out_valid = (cur_ff.count != 2'h0);
    assign push = dma_in_valid && dma_in_ready;
    assign pop = dma_out_valid && dma_out_ready;
    assign step = pvd_step(cur_ff.longword);
    assign total = {cur_ff.pkt, cur_ff.rem};
    assign total_after = total - {21'h0, step};
    // Shared RAM sees only the low counter bits
    assign eff_vme = cur_ff.target ? (cur_ff.vme & pvd_ram_mask(j_ram_bits)) : cur_ff.vme;
    assign head = cur_ff.buffer[cur_ff.rd_ptr];

    // Next state
    always_comb
    begin
        logic [4:0] ofs;
        logic csr_hit;
        nxt_cur = cur_ff;
        ofs = vme_addr[4:0];
        csr_hit = 1'b0;
        nxt_cur.jmp_meta = {csr_base_jumpers, pci_memory_window_lo, pci_memory_window_hi,
                            pci_memory_window_en, shared_ram_window_lo, shared_ram_window_hi,
                            shared_ram_window_en, shared_ram_addr_bits};
        nxt_cur.jmp = cur_ff.jmp_meta;
        nxt_cur.rvalid = 1'b0;

        // VME decode; shared RAM wins where windows overlap
        csr_hit = vme_valid && (vme_space == SPACE_A16) && (vme_addr[15:CSR_OFS_BITS] == j_csr);
        nxt_cur.hits[0] = csr_hit && !ofs[CSR_REMOTE_BIT];
        nxt_cur.hits[1] = csr_hit && ofs[CSR_REMOTE_BIT];
        nxt_cur.hits[3] = vme_valid && pvd_in_window(vme_addr, vme_space, j_ram_lo, j_ram_hi, j_ram_en);
        nxt_cur.hits[2] = vme_valid && !nxt_cur.hits[3]
                          && pvd_in_window(vme_addr, vme_space, j_pci_lo, j_pci_hi, j_pci_en);

        // Two-entry buffer
        if (push)
        begin
            nxt_cur.buffer[cur_ff.wr_ptr] = {dma_in_data, eff_vme, cur_ff.pci};
            nxt_cur.wr_ptr = !cur_ff.wr_ptr;
        end
        if (pop)
        begin
            nxt_cur.rd_ptr = !cur_ff.rd_ptr;
        end
        nxt_cur.count = cur_ff.count + {1'b0, push} - {1'b0, pop};

        // Engine
        if (cur_ff.state == PVD_RUN)
        begin
            nxt_cur.tmo = cur_ff.tmo + 1'b1;
            if (push)
            begin
                nxt_cur.pkt = total_after[23:8];
                nxt_cur.rem = total_after[7:0];
                nxt_cur.pci = cur_ff.pci + {21'h0, step};
                nxt_cur.vme = cur_ff.vme + {29'h0, step};
                if (total_after == 24'h0)
                begin
                    nxt_cur.state = PVD_IDLE;
                end
            end
            if (cur_ff.tmo == TMO_BITS'(TMO_CYCLES - 1))
            begin
                nxt_cur.state = PVD_IDLE;
            end
        end

        // Register writes; DMA setup is frozen while a transfer runs
        if (reg_wr)
        begin
            if (cur_ff.state == PVD_IDLE)
            begin
                case (reg_addr)
                    OFS_CMD:
                    begin
                        nxt_cur.target = reg_wdata[CMD_TARGET];
                        nxt_cur.longword = reg_wdata[CMD_LONG];
                        if (reg_wdata[CMD_START] && total != 24'h0)
                        begin
                            nxt_cur.state = PVD_RUN;
                            nxt_cur.tmo = '0;
                        end
                    end
                    OFS_LOCAL_REM: nxt_cur.local_rem = reg_wdata;
                    OFS_PKT_LO: nxt_cur.pkt[7:0] = reg_wdata;
                    OFS_PKT_HI: nxt_cur.pkt[15:8] = reg_wdata;
                    OFS_PCI_B0: nxt_cur.pci[7:0] = reg_wdata;
                    OFS_PCI_B1: nxt_cur.pci[15:8] = reg_wdata;
                    OFS_PCI_B2: nxt_cur.pci[23:16] = reg_wdata;
                    OFS_REMOTE_REM: nxt_cur.rem = reg_wdata;
                    OFS_VME_B0: nxt_cur.vme[7:0] = reg_wdata;
                    OFS_VME_B1: nxt_cur.vme[15:8] = reg_wdata;
                    OFS_VME_B2: nxt_cur.vme[23:16] = reg_wdata;
                    OFS_VME_B3: nxt_cur.vme[31:24] = reg_wdata;
                    default: ;
                endcase
            end
            if (reg_addr == OFS_SLAVE && reg_wdata[SLV_CLEAR])
            begin
                nxt_cur.slave = 8'h00;
            end
        end

        // Error events land after the clear so a coincident event survives
        if (cur_ff.state == PVD_RUN && cur_ff.tmo == TMO_BITS'(TMO_CYCLES - 1))
        begin
            nxt_cur.slave[SLV_TIMEOUT] = 1'b1;
        end
        if (bus_error_event)
        begin
            nxt_cur.slave[SLV_BUS_ERR] = 1'b1;
        end

        // Register reads; counters are live so progress can be polled
        if (reg_rd)
        begin
            nxt_cur.rvalid = 1'b1;
            case (reg_addr)
                OFS_CMD: nxt_cur.rdata = {cur_ff.state == PVD_RUN, cur_ff.target, 1'b0, cur_ff.longword,
                                          3'h0, cur_ff.state == PVD_RUN};
                OFS_LOCAL_REM: nxt_cur.rdata = cur_ff.local_rem;
                OFS_PKT_LO: nxt_cur.rdata = cur_ff.pkt[7:0];
                OFS_PKT_HI: nxt_cur.rdata = cur_ff.pkt[15:8];
                OFS_PCI_B0: nxt_cur.rdata = cur_ff.pci[7:0];
                OFS_PCI_B1: nxt_cur.rdata = cur_ff.pci[15:8];
                OFS_PCI_B2: nxt_cur.rdata = cur_ff.pci[23:16];
                OFS_REMOTE_REM: nxt_cur.rdata = cur_ff.rem;
                OFS_VME_B0: nxt_cur.rdata = cur_ff.vme[7:0];
                OFS_VME_B1: nxt_cur.rdata = cur_ff.vme[15:8];
                OFS_VME_B2: nxt_cur.rdata = cur_ff.vme[23:16];
                OFS_VME_B3: nxt_cur.rdata = cur_ff.vme[31:24];
                OFS_SLAVE: nxt_cur.rdata = cur_ff.slave;
                default: nxt_cur.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            cur_ff <= '0;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs
    assign reg_rdata = cur_ff.rdata;
    assign reg_rvalid = cur_ff.rvalid;
    assign {hit_shared_ram, hit_pci_memory, hit_csr_remote, hit_csr_local} = cur_ff.hits;
    assign dma_out_data = head.data;
    assign dma_out_vme_addr = head.vme;
    assign dma_out_pci_offset = head.pci[11:0];
    assign dma_out_map_index = head.pci[23:12];
    assign dma_active = (cur_ff.state == PVD_RUN);
    assign dma_to_shared_ram = cur_ff.target;
    assign dma_longword = cur_ff.longword;

    // Checks
    a_start_runs: assert property (@(posedge clock) disable iff (reset)
        (reg_wr && reg_addr == OFS_CMD && reg_wdata[CMD_START] && !dma_active && total != 24'h0)
        |=> dma_active)
        else $error("start with nonzero count did not run");
    a_pci_step: assert property (@(posedge clock) disable iff (reset)
        (push && !reg_wr) |=> cur_ff.pci == $past(cur_ff.pci) + {21'h0, $past(step)})
        else $error("pci address did not step by beat size");
    a_vme_step: assert property (@(posedge clock) disable iff (reset)
        (push && !reg_wr) |=> cur_ff.vme == $past(cur_ff.vme) + {29'h0, $past(step)})
        else $error("vme address did not step by beat size");
    a_count_down: assert property (@(posedge clock) disable iff (reset)
        push |=> {cur_ff.pkt, cur_ff.rem} == $past(total) - {21'h0, $past(step)})
        else $error("byte count did not drop by beat size");
    a_done_zero: assert property (@(posedge clock) disable iff (reset)
        $fell(dma_active) && !$past(cur_ff.tmo == TMO_BITS'(TMO_CYCLES - 1)) |-> total == 24'h0)
        else $error("transfer ended with count left");
    a_timeout_abort: assert property (@(posedge clock) disable iff (reset)
        (dma_active && cur_ff.tmo == TMO_BITS'(TMO_CYCLES - 1))
        |=> !dma_active && cur_ff.slave[SLV_TIMEOUT])
        else $error("timeout did not abort and flag");
    a_slave_clear: assert property (@(posedge clock) disable iff (reset)
        (reg_wr && reg_addr == OFS_SLAVE && reg_wdata[SLV_CLEAR] && !bus_error_event && !dma_active)
        |=> cur_ff.slave == 8'h00)
        else $error("slave status not cleared");
    a_csr_split: assert property (@(posedge clock) disable iff (reset)
        !(hit_csr_local && hit_csr_remote) && !(hit_shared_ram && hit_pci_memory)
        && (!(hit_csr_local || hit_csr_remote) || $past(vme_space) == SPACE_A16))
        else $error("decode hit two targets");
    a_ram_mask: assert property (@(posedge clock) disable iff (reset)
        (push && cur_ff.target) |=> (cur_ff.buffer[$past(cur_ff.wr_ptr)][55:24]
        & ~pvd_ram_mask(j_ram_bits)) == 32'h0)
        else $error("shared ram address has upper bits");
    a_no_overflow: assert property (@(posedge clock) disable iff (reset)
        cur_ff.count <= BUF_DEPTH)
        else $error("buffer overflow");
endmodule // pvd_dma_window
`default_nettype wire

// File: pvd_far_end.sv
// Far-side model of the DMA data stream: beat source and result sink
`timescale 1ns/1ps
`default_nettype none
module pvd_far_end
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Bench controls
    input wire logic feed,
    input wire logic stall,
    // Beats toward the engine
    output logic in_valid,
    input wire logic in_ready,
    output logic [31:0] in_data,
    // Beats from the engine
    output logic out_ready
);
    // Data moves on only once a beat is taken, so a stalled word is never lost
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            in_valid <= 1'b0;
            in_data <= 32'hA5000000;
            out_ready <= 1'b0;
        end
        else
        begin
            in_valid <= feed;
            out_ready <= !stall;
            if (in_valid && in_ready)
                in_data <= in_data + 32'h1;
        end
    end
endmodule // pvd_far_end
`default_nettype wire

// File: pvd_pkg.sv
// Constants, offsets and types for the DMA register and window decode block
`default_nettype none
package pvd_pkg;
    // Register offsets on the byte-wide control and status port
    localparam logic [4:0] OFS_CMD = 5'h10;
    localparam logic [4:0] OFS_LOCAL_REM = 5'h11;
    localparam logic [4:0] OFS_PKT_LO = 5'h12;
    localparam logic [4:0] OFS_PKT_HI = 5'h13;
    localparam logic [4:0] OFS_PCI_B0 = 5'h14;
    localparam logic [4:0] OFS_PCI_B1 = 5'h15;
    localparam logic [4:0] OFS_PCI_B2 = 5'h16;
    localparam logic [4:0] OFS_REMOTE_REM = 5'h18;
    localparam logic [4:0] OFS_VME_B2 = 5'h1A;
    localparam logic [4:0] OFS_VME_B3 = 5'h1B;
    localparam logic [4:0] OFS_VME_B0 = 5'h1C;
    localparam logic [4:0] OFS_VME_B1 = 5'h1D;
    localparam logic [4:0] OFS_SLAVE = 5'h1E;
    // Command register fields
    localparam int CMD_START = 7;
    localparam int CMD_TARGET = 6;
    localparam int CMD_LONG = 4;
    localparam int CMD_ACTIVE = 0;
    // Slave status fields
    localparam int SLV_CLEAR = 7;
    localparam int SLV_TIMEOUT = 0;
    localparam int SLV_BUS_ERR = 1;
    // Beat sizes in bytes
    localparam logic [2:0] STEP_WORD = 3'h2;
    localparam logic [2:0] STEP_LONG = 3'h4;
    // Window and CONTROL_STATUS_REGISTERS space decode
    localparam logic [1:0] SPACE_A16 = 2'h0;
    localparam logic [1:0] SPACE_A24 = 2'h1;
    localparam logic [1:0] SPACE_A32 = 2'h2;
    localparam int WIN_EN_A24 = 0;
    localparam int WIN_EN_A32 = 1;
    localparam int CSR_OFS_BITS = 5;
    localparam int CSR_REMOTE_BIT = 3;
    localparam logic [4:0] RAM_BITS_MIN = 5'h0F;
    localparam logic [4:0] RAM_BITS_MAX = 5'h17;
    // Transfer time limit
    localparam int DMA_TIMEOUT_MS = 16;
    localparam int CLOCK_KHZ = 200000;
    localparam int TIMEOUT_CYCLES = DMA_TIMEOUT_MS * CLOCK_KHZ;
    localparam int TMO_BITS = 22;
    // Buffer
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    localparam int JMP_BITS = 11 + 66 + 66 + 5;
    typedef enum logic [0:0] {PVD_IDLE, PVD_RUN} pvd_state_t;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] vme;
        logic [23:0] pci;
    } pvd_entry_t;
endpackage
`default_nettype wire

// File: test_pvd_dma_window.sv
// Self-checking bench for the DMA register and window decode block
`timescale 1ns/1ps
`default_nettype none
module test_pvd_dma_window;
    import pvd_pkg::*;
    logic clock, reset, reg_wr, reg_rd, reg_rvalid, vme_valid, bus_error_event, feed, stall;
    logic [4:0] reg_addr, ram_bits;
    logic [7:0] reg_wdata, reg_rdata;
    logic [10:0] csr_base;
    logic [31:0] pci_lo, pci_hi, ram_lo, ram_hi, vme_addr, in_data, out_data, out_vme;
    logic [1:0] pci_en, ram_en, vme_space;
    logic hit_cl, hit_cr, hit_pm, hit_sr, in_valid, in_ready, out_valid, out_ready;
    logic [11:0] out_ofs, out_map;
    logic dma_active, to_ram, longword;
    logic [31:0] q_vme[$];
    logic [31:0] q_dat[$];
    logic [23:0] q_pci[$];
    int bad_count = 0;
    int total_checks = 0;

    pvd_dma_window #(.TMO_CYCLES(50)) uut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .csr_base_jumpers(csr_base), .pci_memory_window_lo(pci_lo),
        .pci_memory_window_hi(pci_hi), .pci_memory_window_en(pci_en), .shared_ram_window_lo(ram_lo),
        .shared_ram_window_hi(ram_hi), .shared_ram_window_en(ram_en), .shared_ram_addr_bits(ram_bits),
        .vme_valid(vme_valid), .vme_addr(vme_addr), .vme_space(vme_space), .hit_csr_local(hit_cl),
        .hit_csr_remote(hit_cr), .hit_pci_memory(hit_pm), .hit_shared_ram(hit_sr),
        .dma_in_valid(in_valid), .dma_in_ready(in_ready), .dma_in_data(in_data),
        .dma_out_valid(out_valid), .dma_out_ready(out_ready), .dma_out_data(out_data),
        .dma_out_vme_addr(out_vme), .dma_out_pci_offset(out_ofs), .dma_out_map_index(out_map),
        .bus_error_event(bus_error_event), .dma_active(dma_active), .dma_to_shared_ram(to_ram),
        .dma_longword(longword));

    pvd_far_end far (.clock(clock), .reset(reset), .feed(feed), .stall(stall), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .out_ready(out_ready));

    // Clock at 200 MHz
    always #2.5 clock = ~clock;

    // Record every beat that leaves the buffer
    always @(posedge clock)
    begin
        if (out_valid === 1'b1 && out_ready === 1'b1)
        begin
            q_vme.push_back(out_vme);
            q_pci.push_back({out_map, out_ofs});
            q_dat.push_back(out_data);
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read strobe, then expect the answer one cycle later
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk({reg_rvalid, reg_rdata}, {1'b1, exp});
    endtask

    // Bytes only, in the layout the register port pairs them
    task automatic setup(input logic [15:0] pkt, input logic [7:0] rem, input logic [23:0] pci,
        input logic [31:0] vme);
        wr(OFS_PKT_LO, pkt[7:0]);
        wr(OFS_PKT_HI, pkt[15:8]);
        wr(OFS_REMOTE_REM, rem);
        wr(OFS_LOCAL_REM, rem);
        wr(OFS_PCI_B0, pci[7:0]);
        wr(OFS_PCI_B1, pci[15:8]);
        wr(OFS_PCI_B2, pci[23:16]);
        wr(OFS_VME_B0, vme[7:0]);
        wr(OFS_VME_B1, vme[15:8]);
        wr(OFS_VME_B2, vme[23:16]);
        wr(OFS_VME_B3, vme[31:24]);
        q_vme.delete();
        q_pci.delete();
        q_dat.delete();
    endtask

    // Bounded wait for the engine to go idle, plus time to drain
    task automatic wait_idle(input int n);
        for (int i = 0; i < n && dma_active !== 1'b0; i++)
        begin
            @(posedge clock);
            #1;
        end
        chk(dma_active, 1'b0);
        repeat (4) @(posedge clock);
    endtask

    task automatic t_regs;
        setup(16'hBEEF, 8'h44, 24'h123456, 32'h89ABCDEF);
        rd_chk(OFS_PKT_HI, 8'hBE);
        rd_chk(OFS_PKT_LO, 8'hEF);
        rd_chk(OFS_PCI_B2, 8'h12);
        rd_chk(OFS_PCI_B0, 8'h56);
        rd_chk(OFS_VME_B3, 8'h89);
        rd_chk(OFS_VME_B2, 8'hAB);
        rd_chk(OFS_REMOTE_REM, 8'h44);
        rd_chk(OFS_LOCAL_REM, 8'h44);
        rd_chk(5'h19, 8'h00);
        $display("test regs done");
    endtask

    // Three longword beats while the sink stalls: buffer fills at two, nothing lost
    task automatic t_long_buffer;
        setup(16'h0000, 8'h0C, 24'h000100, 32'h00010000);
        stall <= 1'b1;
        wr(OFS_CMD, 8'h90);
        @(posedge clock);
        #1;
        chk({dma_active, longword, to_ram}, 3'b110);
        @(posedge clock);
        feed <= 1'b1;
        repeat (8) @(posedge clock);
        #1;
        chk({dma_active, in_ready, out_valid}, 3'b101);
        // Setup is frozen while running; command reads show active and longword
        wr(OFS_PKT_LO, 8'hFF);
        rd_chk(OFS_CMD, 8'h91);
        @(posedge clock);
        stall <= 1'b0;
        wait_idle(40);
        feed <= 1'b0;
        chk(q_vme.size(), 3);
        for (int i = 0; i < 3 && i < q_vme.size(); i++)
        begin
            chk(q_vme[i], 32'h00010000 + 4 * i);
            chk(q_pci[i], 24'h000100 + 4 * i);
            chk(q_dat[i], 32'hA5000000 + i);
        end
        rd_chk(OFS_VME_B0, 8'h0C);
        rd_chk(OFS_PKT_LO, 8'h00);
        $display("test long buffer done");
    endtask

    // Word beats into shared RAM: address masked to 15 bits, map index carries
    task automatic t_word_ram;
        setup(16'h0000, 8'h04, 24'hABCFFE, 32'h12345678);
        wr(OFS_CMD, 8'hC0);
        @(posedge clock);
        #1;
        chk({dma_active, longword, to_ram}, 3'b101);
        @(posedge clock);
        feed <= 1'b1;
        wait_idle(40);
        feed <= 1'b0;
        chk(q_vme.size(), 2);
        if (q_vme.size() == 2)
        begin
            chk(q_vme[0], 32'h00005678);
            chk(q_vme[1], 32'h0000567A);
            chk(q_pci[0], 24'hABCFFE);
            chk(q_pci[1], 24'hABD000);
            chk(q_dat[0], 32'hA5000003);
            chk(q_dat[1], 32'hA5000004);
        end
        $display("test word ram done");
    endtask

    // Stalled run is aborted by the time limit; errors then cleared
    task automatic t_timeout;
        setup(16'h0001, 8'h00, 24'h000000, 32'h00000000);
        stall <= 1'b1;
        wr(OFS_CMD, 8'h90);
        @(posedge clock);
        feed <= 1'b1;
        repeat (8) @(posedge clock);
        rd_chk(OFS_PKT_LO, 8'h00);
        @(posedge clock);
        bus_error_event <= 1'b1;
        @(posedge clock);
        bus_error_event <= 1'b0;
        wait_idle(60);
        rd_chk(OFS_SLAVE, 8'h03);
        wr(OFS_SLAVE, 8'h80);
        rd_chk(OFS_SLAVE, 8'h00);
        stall <= 1'b0;
        feed <= 1'b0;
        repeat (4) @(posedge clock);
        $display("test timeout done");
    endtask

    // Window and register-space decode table: {local, remote, pci, ram}
    task automatic t_decode;
        logic [1:0] sp[11] = '{SPACE_A16, SPACE_A16, SPACE_A16, SPACE_A16, SPACE_A16, SPACE_A32,
            SPACE_A32, SPACE_A24, SPACE_A32, SPACE_A24, SPACE_A32};
        logic [31:0] ad[11] = '{32'h00002465, 32'h0000246C, 32'h00002478, 32'h00002471, 32'h00002480,
            32'h20100000, 32'h20200000, 32'h00150000, 32'h3001FFFE, 32'h00010000, 32'h2FFFFFFF};
        logic [3:0] ex[11] = '{4'h8, 4'h4, 4'h4, 4'h8, 4'h0, 4'h2, 4'h0, 4'h2, 4'h1, 4'h0, 4'h0};
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clock);
            vme_valid <= 1'b1;
            vme_space <= sp[i];
            vme_addr <= ad[i];
            @(posedge clock);
            vme_valid <= 1'b0;
            #1;
            chk({hit_cl, hit_cr, hit_pm, hit_sr}, ex[i]);
        end
        $display("test decode done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Static jumpers, idle bus, reset held for five cycles
    initial
    begin
        clock = 1'b0;
        reset = 1'b1;
        {reg_wr, reg_rd, vme_valid, bus_error_event, feed, stall} = 6'h00;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        vme_addr = 32'h00000000;
        vme_space = SPACE_A16;
        csr_base = 11'h123;
        pci_lo = 32'h20100000;
        pci_hi = 32'h20200000;
        pci_en = 2'h3;
        ram_lo = 32'h30000000;
        ram_hi = 32'h30020000;
        ram_en = 2'h2;
        ram_bits = 5'h0F;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        repeat (3) @(posedge clock);
        t_regs();
        t_long_buffer();
        t_word_ram();
        t_timeout();
        t_decode();
        report_and_stop();
    end

    // Watchdog well past the expected run length
    initial
    begin
        repeat (3000) @(posedge clock);
        bad_count++;
        report_and_stop();
    end
endmodule // test_pvd_dma_window
`default_nettype wire
